// >>> inc/serial_tx_pkg.sv
// constants, word carrier and state encoding of the serial transmit port
// assumes one 125 MHz clock and a single lane
package serial_tx_pkg;

   // lane layout
   localparam int CHANNELS = 1;
   localparam int WORD_W = 8;
   localparam int CODE_W = 10;
   localparam int TX_DATA_W = CHANNELS * WORD_W;

   // phase compensation buffer
   localparam int FIFO_AW = 2;
   localparam logic [FIFO_AW:0] FIFO_DEPTH = 3'h4;

   // bit slip select
   localparam int SLIP_W = 4;
   localparam logic [SLIP_W-1:0] SLIP_MAX = 4'h9;

   // word timing: one serial bit per clock, ten bits per word
   localparam logic [3:0] CNT_LAST = 4'h9;
   localparam logic [3:0] CNT_CLK_LOW = 4'h5;
   localparam logic [3:0] CNT_WRITE = 4'h1;
   localparam logic [3:0] CNT_FETCH = 4'h8;

   // register port
   localparam int ADDR_W = 4;
   localparam int REG_W = 8;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
   localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
   localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h8;
   localparam int EV_W = 2;
   localparam int EV_OVERFLOW = 0;
   localparam int EV_UNDERFLOW = 1;
   localparam int CTRL_CORE_CLK = 0;

   // filler sent while the buffer has nothing: K28.5
   localparam logic [WORD_W-1:0] FILL_DATA = 8'hbc;

   typedef struct packed {
      logic ctrl;
      logic force_disp;
      logic disp_val;
      logic [WORD_W-1:0] data;
   } tx_word_t;

   localparam int TX_WORD_BITS = $bits(tx_word_t);

   typedef enum logic [1:0] {
      ST_FILL = 2'b00,
      ST_RUN = 2'b01,
      ST_IDLE = 2'b11
   } tx_state_t;

endpackage

// >>> design/tx_word_ram.sv
// small two-port word store for the phase compensation buffer
// assumes pointers are kept by the caller; read data are registered
`timescale 1ns/100ps
`default_nettype none

module tx_word_ram
   import serial_tx_pkg::*;
(
   // clock
   input wire logic i_clock,
   // write side
   input wire logic i_write,
   input wire logic [FIFO_AW-1:0] i_write_addr,
   input wire tx_word_t i_write_word,
   // read side
   input wire logic i_read,
   input wire logic [FIFO_AW-1:0] i_read_addr,
   output tx_word_t o_read_word
);

   typedef struct packed {
      logic [(1<<FIFO_AW)-1:0][TX_WORD_BITS-1:0] mem;
      logic [TX_WORD_BITS-1:0] rdata;
   } ram_state_t;

   ram_state_t q;
   ram_state_t d;

   always_comb begin
      d = q;
      if (i_write) begin
         d.mem[i_write_addr] = i_write_word;
      end
      if (i_read) begin
         d.rdata = q.mem[i_read_addr];
      end
   end

   // no reset: contents are only read after being written
   always_ff @(posedge i_clock) begin
      q <= d;
   end

   assign o_read_word = tx_word_t'(q.rdata);

endmodule
`default_nettype wire

// >>> design/tx_8b10b_encoder.sv
// combinational 8b/10b encoder, abcdei fghj with a in the msb
// assumes the caller holds running disparity (1 = positive)
`timescale 1ns/100ps
`default_nettype none

module tx_8b10b_encoder
   import serial_tx_pkg::*;
(
   // word in
   input wire logic [WORD_W-1:0] i_data,
   input wire logic i_ctrl,
   input wire logic i_rd,
   // code out
   output logic [CODE_W-1:0] o_code,
   output logic o_rd
);

   // 5b/6b codes for negative running disparity
   localparam logic [5:0] SIX_N [32] = '{
      6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
      6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
   localparam logic [3:0] FOUR_D [8] = '{
      4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
   localparam logic [3:0] FOUR_K [8] = '{
      4'hb, 4'h6, 4'ha, 4'hc, 4'hd, 4'h5, 4'h9, 4'h7};
   localparam logic [5:0] SIX_K28 = 6'h0f;
   localparam logic [4:0] X_K28 = 5'h1c;

   logic [4:0] x;
   logic [2:0] y;
   logic k28;
   logic [5:0] six_n;
   logic [5:0] six;
   logic [3:0] four_n;
   logic [3:0] four;
   logic bal6;
   logic bal4;
   logic rd_mid;
   logic a7;

   always_comb begin
      x = i_data[4:0];
      y = i_data[7:5];
      k28 = i_ctrl && (x == X_K28);
      six_n = k28 ? SIX_K28 : SIX_N[x];
      bal6 = ($countones(six_n) == 3);
      if (!i_rd) begin
         six = six_n;
      end else if (x == 5'h07 && !k28) begin
         six = 6'h07;
      end else if (bal6) begin
         six = six_n;
      end else begin
         six = ~six_n;
      end
      rd_mid = bal6 ? i_rd : ~i_rd;
      // alternate x.7 avoids a run of five inside the code group
      a7 = (y == 3'h7) && (i_ctrl
           || (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14))
           || (rd_mid && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
      four_n = k28 ? FOUR_K[y] : FOUR_D[y];
      if (a7) begin
         four_n = 4'h7;
      end
      bal4 = ($countones(four_n) == 2);
      if (!rd_mid) begin
         four = four_n;
      end else if (y == 3'h3 && !k28) begin
         four = 4'h3;
      end else if (bal4 && !k28) begin
         four = four_n;
      end else begin
         four = ~four_n;
      end
      o_rd = bal4 ? rd_mid : ~rd_mid;
      o_code = {six, four};
   end

endmodule
`default_nettype wire

// >>> design/serial_tx_pcs_port.sv
// transmit coding port: phase buffer, 8b/10b, polarity, bit slip,
// serializer and electrical idle for one lane
// assumes fabric words arrive on o_tx_clkout, or on i_tx_core_clock
// when the control register selects it; registers on a plain port
//
// Functional notes
// - data bus is word width times lanes
// - lane drives its own word clock out
// - optional fabric clock writes the buffer
// - buffer error high when full or empty
// - word controls travel with their data
// - control select picks K or D code
// - force uses disparity value, else running
// - value high negative, low positive disparity
// - invert high flips every code bit
// - slip select 0 to 9 only
// - one serial output per lane
// - force idle drives electrical idle levels
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module serial_tx_pcs_port
   import serial_tx_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // fabric words
   input wire logic [TX_DATA_W-1:0] i_tx_data,
   input wire logic [CHANNELS-1:0] i_tx_ctrl,
   input wire logic [CHANNELS-1:0] i_tx_force_disp,
   input wire logic [CHANNELS-1:0] i_tx_disp_val,
   input wire logic i_tx_core_clock,
   // asynchronous controls
   input wire logic i_tx_invert,
   input wire logic [SLIP_W-1:0] i_tx_slip,
   input wire logic i_tx_force_idle,
   // register port
   input wire logic [ADDR_W-1:0] i_reg_addr,
   input wire logic [REG_W-1:0] i_reg_wdata,
   input wire logic i_reg_write,
   input wire logic i_reg_read,
   output logic [REG_W-1:0] o_reg_rdata,
   // lane outputs
   output logic o_tx_clkout,
   output logic o_phase_fifo_error,
   output logic o_tx_serial,
   output logic o_tx_elec_idle,
   output logic o_irq
);

   typedef struct packed {
      tx_state_t fsm;
      logic [3:0] cnt;
      logic clk_q;
      logic cc_s1;
      logic cc_s2;
      logic cc_s3;
      tx_word_t word_s1;
      tx_word_t word_s2;
      logic inv_s1;
      logic inv_s2;
      logic idl_s1;
      logic idl_s2;
      logic [SLIP_W-1:0] slp_s1;
      logic [SLIP_W-1:0] slp_s2;
      logic [SLIP_W-1:0] slp_s3;
      logic [SLIP_W-1:0] slip_q;
      logic [FIFO_AW:0] wptr;
      logic [FIFO_AW:0] rptr;
      logic have_q;
      logic rd_q;
      logic [CODE_W-1:0] prev;
      logic [CODE_W-1:0] shift;
      logic ser_q;
      logic idle_q;
      logic err_q;
      logic [EV_W-1:0] status;
      logic [EV_W-1:0] mask;
      logic core_sel;
      logic [REG_W-1:0] rdata;
      logic irq_q;
   } port_state_t;

   // the buffer is empty at reset, so the error flag starts high;
   // counter parked on its last count so the first word clock is full width
   localparam port_state_t RESET_STATE = '{fsm: ST_FILL, cnt: CNT_LAST, err_q: 1'b1,
                                           default: '0};

   port_state_t q;
   port_state_t d;

   // buffer and encoder hookups
   logic wr_tick;
   logic wr_en;
   logic rd_en;
   logic full;
   logic empty;
   logic [FIFO_AW:0] level;
   logic [EV_W-1:0] ev;
   tx_word_t rd_word;
   tx_word_t enc_word;
   logic enc_rd_in;
   logic [CODE_W-1:0] enc_code;
   logic enc_rd_out;
   logic [CODE_W-1:0] pcode;
   logic [2*CODE_W-1:0] win;

   ////////////////////////////////////////////////////////////////////
   // submodules

   tx_word_ram u_ram (
      .i_clock(i_clock),
      .i_write(wr_en),
      .i_write_addr(q.wptr[FIFO_AW-1:0]),
      .i_write_word(q.word_s2),
      .i_read(rd_en),
      .i_read_addr(q.rptr[FIFO_AW-1:0]),
      .o_read_word(rd_word)
   );

   tx_8b10b_encoder u_enc (
      .i_data(enc_word.data),
      .i_ctrl(enc_word.ctrl),
      .i_rd(enc_rd_in),
      .o_code(enc_code),
      .o_rd(enc_rd_out)
   );

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      d = q;
      ev = '0;

      // pin synchronizers; first stages feed only the second
      d.cc_s1 = i_tx_core_clock;
      d.cc_s2 = q.cc_s1;
      d.cc_s3 = q.cc_s2;
      d.word_s1 = {i_tx_ctrl[0], i_tx_force_disp[0], i_tx_disp_val[0],
                   i_tx_data[WORD_W-1:0]};
      d.word_s2 = q.word_s1;
      d.inv_s1 = i_tx_invert;
      d.inv_s2 = q.inv_s1;
      d.idl_s1 = i_tx_force_idle;
      d.idl_s2 = q.idl_s1;
      d.slp_s1 = i_tx_slip;
      d.slp_s2 = q.slp_s1;
      d.slp_s3 = q.slp_s2;
      // a bus may skew between bits: take it once two samples agree
      if (q.slp_s2 == q.slp_s3 && q.slp_s3 <= SLIP_MAX) begin
         d.slip_q = q.slp_s3;
      end

      // word divider and the lane word clock
      d.cnt = (q.cnt == CNT_LAST) ? 4'h0 : q.cnt + 4'h1;
      d.clk_q = (d.cnt < CNT_CLK_LOW);

      // buffer write: own word clock, or the fabric clock edge
      if (q.core_sel) begin
         wr_tick = q.cc_s2 & ~q.cc_s3;
      end else begin
         wr_tick = (q.cnt == CNT_WRITE);
      end
      empty = (q.wptr == q.rptr);
      full = (q.wptr[FIFO_AW] != q.rptr[FIFO_AW])
             && (q.wptr[FIFO_AW-1:0] == q.rptr[FIFO_AW-1:0]);
      wr_en = wr_tick & ~full;
      rd_en = (q.cnt == CNT_FETCH) & ~empty;
      if (wr_tick & full) begin
         ev[EV_OVERFLOW] = 1'b1;
      end
      if (q.cnt == CNT_FETCH && empty && q.fsm != ST_FILL) begin
         ev[EV_UNDERFLOW] = 1'b1;
      end
      if (wr_en) begin
         d.wptr = q.wptr + 3'h1;
      end
      if (rd_en) begin
         d.rptr = q.rptr + 3'h1;
      end
      if (q.cnt == CNT_FETCH) begin
         d.have_q = ~empty;
      end
      level = d.wptr - d.rptr;
      d.err_q = (level == 3'h0) || (level == FIFO_DEPTH);

      // encode the fetched word, or filler when none came
      if (q.have_q) begin
         enc_word = rd_word;
      end else begin
         enc_word = {1'b1, 1'b0, 1'b0, FILL_DATA};
      end
      if (enc_word.force_disp) begin
         enc_rd_in = ~enc_word.disp_val;
      end else begin
         enc_rd_in = q.rd_q;
      end
      pcode = enc_code ^ {CODE_W{q.inv_s2}};
      win = {q.prev, pcode};

      // serializer: msb first, reload on the last bit of a word
      if (q.cnt == CNT_LAST) begin
         d.rd_q = enc_rd_out;
         d.prev = pcode;
         d.shift = CODE_W'(win >> q.slip_q);
      end else begin
         d.shift = {q.shift[CODE_W-2:0], 1'b0};
      end

      // lane state
      case (q.fsm)
         ST_FILL: begin
            // idle is honoured even before the first word arrives
            if (q.idl_s2) begin
               d.fsm = ST_IDLE;
            end else if (q.cnt == CNT_LAST && q.have_q) begin
               d.fsm = ST_RUN;
            end
         end
         ST_RUN: begin
            if (q.idl_s2) begin
               d.fsm = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (!q.idl_s2) begin
               d.fsm = ST_RUN;
            end
         end
         default: begin
            d.fsm = ST_FILL;
         end
      endcase

      // idle holds the line quiet; words keep draining meanwhile
      d.idle_q = (d.fsm == ST_IDLE);
      d.ser_q = d.idle_q ? 1'b0 : q.shift[CODE_W-1];

      // register port
      d.rdata = '0;
      if (i_reg_read) begin
         case (i_reg_addr)
            REG_STATUS: begin
               d.rdata = REG_W'(q.status);
            end
            REG_MASK: begin
               d.rdata = REG_W'(q.mask);
            end
            REG_CONTROL: begin
               d.rdata = REG_W'(q.core_sel);
            end
            default: begin
               d.rdata = '0;
            end
         endcase
      end
      if (i_reg_write) begin
         case (i_reg_addr)
            REG_MASK: begin
               d.mask = i_reg_wdata[EV_W-1:0];
            end
            REG_CONTROL: begin
               d.core_sel = i_reg_wdata[CTRL_CORE_CLK];
            end
            default: begin
               d.mask = q.mask;
            end
         endcase
      end
      // read clears, but an event in the same cycle survives
      if (i_reg_read && i_reg_addr == REG_STATUS) begin
         d.status = ev;
      end else begin
         d.status = q.status | ev;
      end
      d.irq_q = |(d.status & d.mask);
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         q <= RESET_STATE;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, all straight from flops

   assign o_reg_rdata = q.rdata;
   assign o_tx_clkout = q.clk_q;
   assign o_phase_fifo_error = q.err_q;
   assign o_tx_serial = q.ser_q;
   assign o_tx_elec_idle = q.idle_q;
   assign o_irq = q.irq_q;

endmodule
`default_nettype wire

// >>> dv/serial_tx_fabric_model.sv
// fabric side model: hands the port one word per word clock period
// assumes the bench chooses the word; shares i_clock with the port
`timescale 1ns/100ps
`default_nettype none

module serial_tx_fabric_model
   import serial_tx_pkg::*;
(
   // clocks
   input wire logic i_clock,
   input wire logic i_tx_clkout,
   // word chosen by the bench
   input wire tx_word_t i_word,
   // to the port
   output var tx_word_t o_word
);
   logic prev_q = 1'b0;

   initial o_word = '0;

   always @(posedge i_clock) begin
      prev_q <= i_tx_clkout;
      // change only after the word clock rises, never mid-period
      if (i_tx_clkout && !prev_q) begin
         o_word <= i_word;
      end
   end
endmodule

`default_nettype wire

// >>> dv/serial_tx_pcs_port_chk.sv
// port checker for the serial transmit port
// assumes one clock and the synchronous active high reset
`timescale 1ns/100ps
`default_nettype none

module serial_tx_pcs_port_chk
   import serial_tx_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset,
   // watched inputs
   input wire logic i_tx_force_idle,
   input wire logic [ADDR_W-1:0] i_reg_addr,
   input wire logic i_reg_read,
   // watched outputs
   input wire logic [REG_W-1:0] o_reg_rdata,
   input wire logic o_tx_clkout,
   input wire logic o_phase_fifo_error,
   input wire logic o_tx_serial,
   input wire logic o_tx_elec_idle,
   input wire logic o_irq
);
   default clocking cb @(posedge i_clock); endclocking

   logic unmapped;
   assign unmapped = i_reg_addr != REG_STATUS && i_reg_addr != REG_MASK
      && i_reg_addr != REG_CONTROL;

   clk_period_a: assert property (disable iff (i_reset)
      $rose(o_tx_clkout) |-> ##10 $rose(o_tx_clkout)) else $error("word clock period");
   clk_high_a: assert property (disable iff (i_reset)
      $rose(o_tx_clkout) |-> o_tx_clkout [*5] ##1 !o_tx_clkout) else $error("word clock high");
   err_reset_a: assert property (i_reset |=> o_phase_fifo_error)
      else $error("buffer error low in reset");
   idle_quiet_a: assert property (disable iff (i_reset)
      o_tx_elec_idle |-> !o_tx_serial) else $error("serial active in idle");
   idle_on_a: assert property (disable iff (i_reset)
      i_tx_force_idle [*5] |-> o_tx_elec_idle) else $error("idle not entered");
   idle_off_a: assert property (disable iff (i_reset)
      (!i_tx_force_idle) [*5] |-> !o_tx_elec_idle) else $error("idle not left");
   rdata_gap_a: assert property (disable iff (i_reset)
      !i_reg_read |=> o_reg_rdata == 8'h00) else $error("read data without read");
   rdata_unmapped_a: assert property (disable iff (i_reset)
      i_reg_read && unmapped |=> o_reg_rdata == 8'h00) else $error("unmapped read data");
   quiet_reset_a: assert property (i_reset |=> !o_irq && !o_tx_serial)
      else $error("outputs active in reset");
endmodule

bind serial_tx_pcs_port serial_tx_pcs_port_chk u_chk (
   .i_clock(i_clock),
   .i_reset(i_reset),
   .i_tx_force_idle(i_tx_force_idle),
   .i_reg_addr(i_reg_addr),
   .i_reg_read(i_reg_read),
   .o_reg_rdata(o_reg_rdata),
   .o_tx_clkout(o_tx_clkout),
   .o_phase_fifo_error(o_phase_fifo_error),
   .o_tx_serial(o_tx_serial),
   .o_tx_elec_idle(o_tx_elec_idle),
   .o_irq(o_irq)
);

`default_nettype wire

// >>> dv/test_serial_tx_pcs_port.sv
// bench for the serial transmit port: register calls and line patterns
// assumes the fabric model and the bound checker are compiled with it
`timescale 1ns/100ps
`default_nettype none

module test_serial_tx_pcs_port
   import serial_tx_pkg::*;
;

   logic i_clock, i_reset, i_tx_core_clock, i_tx_invert, i_tx_force_idle;
   logic i_reg_write, i_reg_read, o_tx_clkout, o_phase_fifo_error;
   logic o_tx_serial, o_tx_elec_idle, o_irq, seen, low_seen, clk_prev;
   logic [SLIP_W-1:0] i_tx_slip;
   logic [ADDR_W-1:0] i_reg_addr;
   logic [REG_W-1:0] i_reg_wdata, o_reg_rdata;
   logic [9:0] win, frame;
   tx_word_t word, fab;
   int err_total, total_checks, n_neg, n_pos, n_alt;

   serial_tx_fabric_model u_fab (.i_clock(i_clock), .i_tx_clkout(o_tx_clkout),
      .i_word(word), .o_word(fab));

   serial_tx_pcs_port u_dut (.i_clock(i_clock), .i_reset(i_reset),
      .i_tx_data(fab.data),
      .i_tx_ctrl(fab.ctrl), .i_tx_force_disp(fab.force_disp),
      .i_tx_disp_val(fab.disp_val), .i_tx_core_clock(i_tx_core_clock),
      .i_tx_invert(i_tx_invert), .i_tx_slip(i_tx_slip),
      .i_tx_force_idle(i_tx_force_idle), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
      .o_reg_rdata(o_reg_rdata), .o_tx_clkout(o_tx_clkout),
      .o_phase_fifo_error(o_phase_fifo_error), .o_tx_serial(o_tx_serial),
      .o_tx_elec_idle(o_tx_elec_idle), .o_irq(o_irq));

   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end

   // line alignment unknown, so count code groups in a sliding window
   always @(posedge i_clock) begin
      win = {win[8:0], o_tx_serial};
      n_neg += int'(win === 10'h0fa);
      n_pos += int'(win === 10'h305);
      n_alt += int'(win === 10'h2aa);
      // a whole code group sits in win just as the word clock is seen high
      if (o_tx_clkout && !clk_prev) begin
         frame = win;
      end
      clk_prev = o_tx_clkout;
   end

   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask

   task wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
      @(posedge i_clock);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_write <= 1'b1;
      @(posedge i_clock);
      i_reg_write <= 1'b0;
   endtask

   task rdc(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e, input logic [REG_W-1:0] m);
      @(posedge i_clock);
      i_reg_addr <= a;
      i_reg_read <= 1'b1;
      @(posedge i_clock);
      i_reg_read <= 1'b0;
      #1 chk(o_reg_rdata & m, e);
   endtask

   // settle past buffer and sync delay, then count a fresh window
   task watch(input tx_word_t w);
      word <= w;
      repeat (60) @(posedge i_clock);
      n_neg = 0;
      n_pos = 0;
      n_alt = 0;
      repeat (60) @(posedge i_clock);
   endtask

   task finish_test;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      err_total++;
      finish_test;
   end

   initial begin
      i_reset = 1'b1;
      {i_tx_core_clock, i_tx_invert, i_tx_force_idle, i_reg_write, i_reg_read} = '0;
      i_tx_slip = '0;
      i_reg_addr = '0;
      i_reg_wdata = '0;
      word = '0;
      win = '0;
      repeat (12) @(posedge i_clock);
      i_reset <= 1'b0;
      rdc(4'h2, 8'h00, 8'hff);
      wr(REG_MASK, 8'h03);
      rdc(REG_MASK, 8'h03, 8'hff);
      watch('{1'b1, 1'b1, 1'b1, 8'hbc});
      chk(8'(n_neg > 0), 8'h01);
      chk(8'(n_pos == 0), 8'h01);
      chk(8'(frame == 10'h0fa), 8'h01);
      i_tx_invert <= 1'b1;
      watch('{1'b1, 1'b1, 1'b1, 8'hbc});
      chk(8'(n_pos > 0 && n_neg == 0), 8'h01);
      chk(8'(frame == 10'h305), 8'h01);
      i_tx_invert <= 1'b0;
      watch('{1'b1, 1'b1, 1'b0, 8'hbc});
      chk(8'(n_pos > 0 && n_neg == 0), 8'h01);
      watch('{1'b1, 1'b0, 1'b0, 8'hbc});
      chk(8'(n_pos > 0 && n_neg > 0), 8'h01);
      watch('{1'b0, 1'b0, 1'b0, 8'hb5});
      chk(8'(n_alt > 0), 8'h01);
      i_tx_slip <= 4'h9;
      watch('{1'b1, 1'b1, 1'b1, 8'hbc});
      chk(8'(n_neg > 0 && n_pos == 0), 8'h01);
      chk(8'(frame == 10'h1f4), 8'h01);
      i_tx_force_idle <= 1'b1;
      repeat (6) @(posedge i_clock);
      chk(8'(o_tx_elec_idle), 8'h01);
      i_tx_force_idle <= 1'b0;
      // core clock mode with no core edges starves the buffer
      rdc(REG_STATUS, 8'h00, 8'hff);
      wr(REG_CONTROL, 8'h01);
      rdc(REG_CONTROL, 8'h01, 8'hff);
      repeat (80) @(posedge i_clock);
      chk(8'(o_irq), 8'h01);
      chk(8'(o_phase_fifo_error), 8'h01);
      rdc(REG_STATUS, 8'h02, 8'hff);
      wr(REG_MASK, 8'h00);
      repeat (2) @(posedge i_clock);
      chk(8'(o_irq), 8'h00);
      // core edges every 6 cycles outrun one read per 10
      seen = 1'b0;
      low_seen = 1'b0;
      for (int i = 0; i < 40; i++) begin
         repeat (3) @(posedge i_clock);
         i_tx_core_clock <= ~i_tx_core_clock;
         // skip the start, where the flag is still high for empty
         if (i > 10) begin
            seen = seen | o_phase_fifo_error;
            low_seen = low_seen | !o_phase_fifo_error;
         end
      end
      chk(8'(seen), 8'h01);
      chk(8'(low_seen), 8'h01);
      rdc(REG_STATUS, 8'h01, 8'h01);
      wr(REG_CONTROL, 8'h00);
      finish_test;
   end
endmodule

`default_nettype wire
